//--- src/input_reference_config_page.sv
// Input reference configuration page with Wishbone slave and receive logic
//
// The Wishbone register port was decided locally.
`timescale 1ns/100ps

module input_reference_config_page
  import ref_page_pkg::*;
#(
  parameter int NREF = 10, // Reference inputs fitted
  parameter int MASK_W = 12, // Width of the select mask
  parameter int ADR_W = 16 // Wishbone byte address width
)(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [ADR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic [NREF-1:0] reference_input_pin_i,
  output logic [NREF-1:0] ref_clk_o,
  output logic [NREF-1:0] diff_mode_o,
  output logic [NREF-1:0] lvpecl_mode_o,
  output logic [NREF-1:0] phase_acq_en_o,
  output logic [NREF-1:0] phase_acq_pd_o,
  output logic [EXP_W-1:0] expected_hz_o
);

  // ************************************************
  // Storage
  // ************************************************
  ref_cfg_s page_r; // Page seen by software
  ref_cfg_s cfg_r [NREF]; // Applied per-reference configuration
  logic [MASK_W-1:0] mask_r; // Reference select mask
  logic [1:0] sem_r; // Read and write request bits
  xfer_state_e state_r; // Page transfer state
  logic [31:0] rd_nxt; // Read data for the addressed register
  logic [13:0] idx; // Word index from the byte address
  logic req; // New bus request this cycle
  logic wr; // New bus write this cycle
  logic [3:0] load_idx; // Lowest masked reference
  logic load_ok; // A masked reference exists

  assign idx = 14'(adr_i[ADR_W-1:2]);
  assign req = cyc_i && stb_i && !ack_o;
  assign wr = req && we_i;

  // Merge byte lanes into a 16-bit field
  function automatic logic [15:0] lane16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
    lane16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  // ************************************************
  // Wishbone answer
  // ************************************************
  // Every request is answered one cycle later; unmapped words read zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end
    else
    begin
      ack_o <= req;
      dat_o <= (req && !we_i) ? rd_nxt : 32'h0000_0000;
    end
  end

  // Read decode
  always_comb
  begin
    rd_nxt = 32'h0000_0000;
    if (idx == IDX_MASK)
      rd_nxt = 32'(mask_r);
    else if (idx == IDX_SEM)
      rd_nxt = 32'(sem_r);
    else if (idx == IDX_BASE)
      rd_nxt = 32'(page_r.base);
    else if (idx == IDX_MULT)
      rd_nxt = 32'(page_r.mult);
    else if (idx == IDX_NUM)
      rd_nxt = 32'(page_r.num);
    else if (idx == IDX_DEN)
      rd_nxt = 32'(page_r.den);
    else if (idx == IDX_SETUP)
      rd_nxt = 32'(page_r.setup & SETUP_WMASK);
    else if (idx == IDX_EXP_LO)
      rd_nxt = expected_hz_o[31:0];
    else if (idx == IDX_EXP_HI)
      rd_nxt = 32'(expected_hz_o[EXP_W-1:32]);
  end

  // ************************************************
  // Page registers
  // ************************************************
  // A load from a reference overrides a bus write in the same cycle
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      page_r <= RST_CFG;
    else if (state_r == ST_LOAD && load_ok)
      page_r <= cfg_r[load_idx];
    else if (wr)
    begin
      if (idx == IDX_BASE)
        page_r.base <= lane16(page_r.base, dat_i, sel_i);
      else if (idx == IDX_MULT)
        page_r.mult <= lane16(page_r.mult, dat_i, sel_i);
      else if (idx == IDX_NUM)
        page_r.num <= lane16(page_r.num, dat_i, sel_i);
      else if (idx == IDX_DEN)
        page_r.den <= lane16(page_r.den, dat_i, sel_i);
      else if (idx == IDX_SETUP && sel_i[0])
        page_r.setup <= dat_i[7:0] & SETUP_WMASK;
    end
  end

  // Mask register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      mask_r <= RST_MASK;
    else if (wr && idx == IDX_MASK)
      mask_r <= {sel_i[1] ? dat_i[MASK_W-1:8] : mask_r[MASK_W-1:8], sel_i[0] ? dat_i[7:0] : mask_r[7:0]};
  end

  // ************************************************
  // Page transfer
  // ************************************************
  // Lowest masked reference; a read should name only one
  always_comb
  begin
    load_idx = 4'h0;
    load_ok = 1'b0;
    for (int k = NREF - 1; k >= 0; k--)
    begin
      if (mask_r[k])
      begin
        load_idx = 4'(k);
        load_ok = 1'b1;
      end
    end
  end

  // Semaphore: a host set in the clearing cycle wins over the clear
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      sem_r <= 2'b00;
    else if (wr && idx == IDX_SEM && sel_i[0])
      sem_r <= sem_r | dat_i[1:0];
    else if (state_r != ST_IDLE)
      sem_r <= 2'b00;
  end

  // Transfer state machine; a read request has priority
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      state_r <= ST_IDLE;
    else
    begin
      case (state_r)
        ST_IDLE:
        begin
          if (sem_r[SEM_RD])
            state_r <= ST_LOAD;
          else if (sem_r[SEM_WR])
            state_r <= ST_APPLY;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Applied configuration, one copy per reference
  always_ff @(posedge clk_i)
  begin
    for (int k = 0; k < NREF; k++)
    begin
      if (rst_i)
        cfg_r[k] <= RST_CFG;
      else if (state_r == ST_APPLY && mask_r[k])
        cfg_r[k] <= page_r;
    end
  end

  // ************************************************
  // Expected frequency
  // ************************************************
  // Serial divider keeps area small; result trails a change by 49 cycles
  logic [EXP_W-1:0] prod; // Base times multiple times numerator
  logic [63:0] snap_r; // Factors of the running division
  logic [EXP_W-1:0] dvd_r; // Dividend shifting into quotient
  logic [15:0] rem_r; // Partial remainder
  logic [5:0] cnt_r; // Steps left
  logic [16:0] rem_sh; // Remainder with next dividend bit
  logic take; // Quotient bit

  // Operands widened first so the product never wraps at 16 bits
  assign prod = EXP_W'(page_r.base) * EXP_W'(page_r.mult) * EXP_W'(page_r.num);
  assign rem_sh = {rem_r, dvd_r[EXP_W-1]};
  assign take = rem_sh >= {1'b0, snap_r[15:0]};

  // Restart on any factor change, shift otherwise
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      snap_r <= 64'h0000_0000_0000_0000;
      dvd_r <= '0;
      rem_r <= 16'h0000;
      cnt_r <= 6'h00;
      expected_hz_o <= '0;
    end
    else if (snap_r != {page_r.base, page_r.mult, page_r.num, page_r.den})
    begin
      snap_r <= {page_r.base, page_r.mult, page_r.num, page_r.den};
      dvd_r <= prod;
      rem_r <= 16'h0000;
      cnt_r <= DIV_STEPS;
    end
    else if (cnt_r != 6'h00)
    begin
      rem_r <= take ? 16'(rem_sh - {1'b0, snap_r[15:0]}) : rem_sh[15:0];
      dvd_r <= {dvd_r[EXP_W-2:0], take};
      cnt_r <= cnt_r - 6'h01;
      if (cnt_r == 6'h01)
        expected_hz_o <= (snap_r[15:0] == 16'h0000) ? '1 : {dvd_r[EXP_W-2:0], take};
    end
  end

  // ************************************************
  // Reference receive path
  // ************************************************
  logic [NREF-1:0] s1_r, s2_r, s3_r; // Three-stage pin synchroniser
  logic [NREF-1:0] lvl_r; // Settled pin level
  logic [NREF-1:0] rx_r; // Received reference
  logic [NREF-1:0] rx_q; // Previous received value
  logic [NREF-1:0] half_r; // Divide-by-two toggle

  // A change counts once the second and third stages agree
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      lvl_r <= '0;
    end
    else
    begin
      s1_r <= reference_input_pin_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      lvl_r <= (s2_r & s3_r) | (lvl_r & (s2_r | s3_r));
    end
  end

  for (genvar j = 0; j < NREF; j++)
  begin : g_ref
    localparam int EVEN = j - (j % 2); // Even member of the pair
    localparam bit ODD = (j % 2) == 1;
    logic pair_diff; // Even member runs differential
    assign pair_diff = cfg_r[EVEN].setup[SETUP_DIFF];

    // Even input in differential mode follows the sign of P minus N
    always_ff @(posedge clk_i)
    begin
      if (rst_i)
      begin
        rx_r[j] <= 1'b0;
        rx_q[j] <= 1'b0;
        half_r[j] <= 1'b0;
        ref_clk_o[j] <= 1'b0;
      end
      else
      begin
        if (!ODD && pair_diff && (j + 1 < NREF))
        begin
          if (lvl_r[j] != lvl_r[(j + 1) % NREF])
            rx_r[j] <= lvl_r[j];
        end
        else
          rx_r[j] <= lvl_r[j];
        rx_q[j] <= rx_r[j];
        if (rx_r[j] && !rx_q[j])
          half_r[j] <= !half_r[j];
        if (cfg_r[j].setup[SETUP_PREDIV])
          ref_clk_o[j] <= half_r[j];
        else
          ref_clk_o[j] <= rx_r[j];
      end
    end

    // Receiver mode and acquisition power
    always_ff @(posedge clk_i)
    begin
      if (rst_i)
      begin
        diff_mode_o[j] <= 1'b0;
        lvpecl_mode_o[j] <= 1'b0;
        phase_acq_en_o[j] <= RST_SETUP[SETUP_EN];
        phase_acq_pd_o[j] <= !RST_SETUP[SETUP_EN];
      end
      else
      begin
        diff_mode_o[j] <= !ODD && pair_diff && (j + 1 < NREF);
        lvpecl_mode_o[j] <= cfg_r[j].setup[SETUP_LVPECL] && !pair_diff;
        phase_acq_en_o[j] <= cfg_r[j].setup[SETUP_EN];
        phase_acq_pd_o[j] <= !cfg_r[j].setup[SETUP_EN];
      end
    end
  end

  // ************************************************
  // Assertions
  // ************************************************
  property p_exp_hz;
    @(posedge clk_i) disable iff (rst_i)
    (cnt_r == 6'h01 && snap_r[15:0] != 16'h0000 && snap_r == {page_r.base, page_r.mult, page_r.num, page_r.den})
      |=> (64'(expected_hz_o) * page_r.den <= 64'(prod)) && (64'(prod) < (64'(expected_hz_o) + 1) * page_r.den);
  endproperty
  a_exp_hz: assert property (p_exp_hz) else $error("expected frequency wrong");

  property p_base_wr;
    @(posedge clk_i) disable iff (rst_i)
    (wr && idx == IDX_BASE && sel_i[1:0] == 2'b11 && state_r != ST_LOAD) |=> page_r.base == $past(dat_i[15:0]);
  endproperty
  a_base_wr: assert property (p_base_wr) else $error("base frequency not written");

  property p_rst_vals;
    @(posedge clk_i) $past(rst_i) && !rst_i |-> page_r.base == RST_BASE && page_r.mult == RST_MULT
      && page_r.num == RST_NUM && page_r.den == RST_DEN && page_r.setup == RST_SETUP;
  endproperty
  a_rst_vals: assert property (p_rst_vals) else $error("page reset value wrong");

  property p_nodiv;
    @(posedge clk_i) disable iff (rst_i)
    !cfg_r[0].setup[SETUP_PREDIV] ##1 !cfg_r[0].setup[SETUP_PREDIV] |-> ref_clk_o[0] == $past(rx_r[0]);
  endproperty
  a_nodiv: assert property (p_nodiv) else $error("undivided reference wrong");

  property p_half;
    @(posedge clk_i) disable iff (rst_i)
    (cfg_r[0].setup[SETUP_PREDIV] && rx_r[0] && !rx_q[0]) ##1 cfg_r[0].setup[SETUP_PREDIV]
      |=> ref_clk_o[0] != $past(ref_clk_o[0]);
  endproperty
  a_half: assert property (p_half) else $error("divided reference did not toggle");

  property p_lvpecl;
    @(posedge clk_i) disable iff (rst_i)
    cfg_r[0].setup[SETUP_DIFF] |=> !lvpecl_mode_o[0] && !lvpecl_mode_o[1] && !diff_mode_o[1];
  endproperty
  a_lvpecl: assert property (p_lvpecl) else $error("pair setting not ignored");

  property p_acq;
    @(posedge clk_i) disable iff (rst_i)
    1'b1 |=> phase_acq_en_o[0] == $past(cfg_r[0].setup[SETUP_EN]) && phase_acq_pd_o[0] == !phase_acq_en_o[0];
  endproperty
  a_acq: assert property (p_acq) else $error("acquisition enable wrong");

  property p_resv;
    @(posedge clk_i) disable iff (rst_i)
    (req && !we_i && idx == IDX_SETUP) |=> ack_o && dat_o[7:5] == 3'b000 && !dat_o[3];
  endproperty
  a_resv: assert property (p_resv) else $error("reserved setup bits not zero");

  property p_apply;
    @(posedge clk_i) disable iff (rst_i)
    (state_r == ST_IDLE && sem_r == 2'b01 && mask_r[0] && !wr) |=> ##1 cfg_r[0] == $past(page_r) && sem_r == 2'b00;
  endproperty
  a_apply: assert property (p_apply) else $error("page write not applied");

  property p_load;
    @(posedge clk_i) disable iff (rst_i)
    (state_r == ST_IDLE && sem_r[SEM_RD] && !wr) |-> ##[1:2] state_r == ST_LOAD ##1 sem_r == 2'b00;
  endproperty
  a_load: assert property (p_load) else $error("page read not completed");

endmodule

//--- src/ref_page_pkg.sv
// Shared constants and types of the input reference configuration page
package ref_page_pkg;

  // ************************************************
  // Register indices (byte address is four times the index)
  // ************************************************
  localparam logic [13:0] IDX_MASK = 14'h0582; // Reference select mask
  localparam logic [13:0] IDX_SEM = 14'h0584; // Page transfer semaphore
  localparam logic [13:0] IDX_BASE = 14'h0585; // input_base_frequency
  localparam logic [13:0] IDX_MULT = 14'h0587; // input_frequency_multiple
  localparam logic [13:0] IDX_NUM = 14'h0589; // fec_ratio_numerator
  localparam logic [13:0] IDX_DEN = 14'h058B; // fec_ratio_denominator
  localparam logic [13:0] IDX_SETUP = 14'h058D; // input_reference_setup
  localparam logic [13:0] IDX_EXP_LO = 14'h05A0; // Expected frequency, bits 31:0
  localparam logic [13:0] IDX_EXP_HI = 14'h05A1; // Expected frequency, bits 47:32

  // ************************************************
  // Reset values
  // ************************************************
  localparam logic [15:0] RST_BASE = 16'h9C40;
  localparam logic [15:0] RST_MULT = 16'h0001;
  localparam logic [15:0] RST_NUM = 16'h0001;
  localparam logic [15:0] RST_DEN = 16'h0001;
  localparam logic [7:0] RST_SETUP = 8'h01;
  localparam logic [11:0] RST_MASK = 12'h000;

  // ************************************************
  // Setup field positions and semaphore bits
  // ************************************************
  localparam int SETUP_EN = 0; // Phase acquisition enable
  localparam int SETUP_LVPECL = 1; // Single-ended LVPECL receive
  localparam int SETUP_DIFF = 2; // Differential receive
  localparam int SETUP_PREDIV = 4; // Divide by two ahead of the PLLs
  localparam logic [7:0] SETUP_WMASK = 8'h17; // Writable setup bits
  localparam int SEM_WR = 0; // Write page to masked references
  localparam int SEM_RD = 1; // Read masked reference into page

  // ************************************************
  // Timing and sizes
  // ************************************************
  localparam int EXP_W = 48; // Width of base*mult*num
  localparam logic [5:0] DIV_STEPS = 6'd48; // One quotient bit per cycle

  // Page transfer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_APPLY = 2'b01,
    ST_LOAD = 2'b10
  } xfer_state_e;

  // One reference's configuration
  typedef struct packed {
    logic [15:0] base;
    logic [15:0] mult;
    logic [15:0] num;
    logic [15:0] den;
    logic [7:0] setup;
  } ref_cfg_s;

  localparam ref_cfg_s RST_CFG = '{RST_BASE, RST_MULT, RST_NUM, RST_DEN, RST_SETUP};

endpackage

//--- verif/ref_host_model.sv
// Host controller model: Wishbone master plus page transfer handshakes
`timescale 1ns/100ps
module ref_host_model
  import ref_page_pkg::*;
(
  input wire logic clk_i,
  input wire logic ack_i,
  input wire logic [31:0] dat_i,
  output logic cyc_o,
  output logic stb_o,
  output logic we_o,
  output logic [15:0] adr_o,
  output logic [3:0] sel_o,
  output logic [31:0] dat_o
);
  // ************************************************
  // Bus idle at time zero
  // ************************************************
  initial
  begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o = 1'b0;
    adr_o = 16'h0000;
    sel_o = 4'h0;
    dat_o = 32'h0000_0000;
  end

  // One classic cycle; holds everything until ack is sampled high
  task automatic xfer(input logic w, input logic [13:0] idx, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= w;
    adr_o <= {idx, 2'b00};
    sel_o <= 4'hF;
    dat_o <= wd;
    // No fixed latency assumed; the bench watchdog ends a hang
    do
      @(posedge clk_i);
    while (ack_i !== 1'b1);
    rd = dat_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    // Released data lines flip so a stale word never looks valid
    dat_o <= ~wd;
  endtask

  // Select references, request the transfer, poll until the semaphore clears
  task automatic page_xfer(input logic [11:0] mask, input logic rd_req, output int polls,
                           output logic [31:0] sem);
    xfer(1'b1, IDX_MASK, {20'h00000, mask}, sem);
    xfer(1'b1, IDX_SEM, rd_req ? 32'h0000_0002 : 32'h0000_0001, sem);
    polls = 0;
    // Bounded poll: a stuck semaphore shows up as a count of 16
    do
    begin
      xfer(1'b0, IDX_SEM, 32'h0000_0000, sem);
      polls++;
    end
    while (sem[1:0] !== 2'b00 && polls < 16);
  endtask
endmodule

//--- verif/tb_top.sv
// Self-checking testbench of the input reference configuration page
`timescale 1ns/100ps
module tb_top;
  import ref_page_pkg::*;
  logic clk_i;
  logic rst_i;
  logic cyc, stb, we, ack;
  logic [15:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat;
  logic [9:0] pins_i, ref_clk, diff, lvpecl, acq_en, acq_pd;
  logic [47:0] exp_hz;
  int bad_count = 0;
  int checked = 0;
  int polls;
  logic [31:0] v;
  // Factor registers in one table so loops cover them alike
  logic [13:0] fidx [4] = '{IDX_BASE, IDX_MULT, IDX_NUM, IDX_DEN};
  logic [15:0] frst [4] = '{RST_BASE, RST_MULT, RST_NUM, RST_DEN};
  logic [15:0] fpat [4] = '{16'hA5C3, 16'h5A3C, 16'h0F0F, 16'hF0F0};

  input_reference_config_page uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .reference_input_pin_i(pins_i),
    .ref_clk_o(ref_clk), .diff_mode_o(diff), .lvpecl_mode_o(lvpecl), .phase_acq_en_o(acq_en),
    .phase_acq_pd_o(acq_pd), .expected_hz_o(exp_hz));
  ref_host_model host (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb), .we_o(we),
    .adr_o(adr), .sel_o(sel), .dat_o(wdat));

  // ************************************************
  // Clock, reset and watchdog
  // ************************************************
  initial
  begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  // Whole run needs about 600 cycles; over thirty times that means a hang
  initial
  begin
    repeat (20000) @(posedge clk_i);
    bad_count++;
    report_and_stop();
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [47:0] exp, input logic [47:0] got);
    checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask

  // Read a register and compare its word
  task automatic rd_chk(input string nm, input logic [13:0] idx, input logic [31:0] exp);
    host.xfer(1'b0, idx, 32'h0000_0000, v);
    chk(nm, {16'h0000, exp}, {16'h0000, v});
  endtask

  // ************************************************
  // Scenarios
  // ************************************************
  task automatic t_reset();
    repeat (60) @(posedge clk_i);
    for (int i = 0; i < 4; i++)
      rd_chk("factor reset", fidx[i], {16'h0000, frst[i]});
    rd_chk("setup reset", IDX_SETUP, 32'h0000_0001);
    chk("acq en reset", 48'h3FF, {38'h0, acq_en});
    chk("expected reset", 48'd40000, exp_hz);
    $display("test reset done");
  endtask

  task automatic t_regs();
    for (int i = 0; i < 4; i++)
    begin
      host.xfer(1'b1, fidx[i], {16'hFFFF, fpat[i]}, v);
      rd_chk("factor rw", fidx[i], {16'h0000, fpat[i]});
    end
    // Reserved setup bits must drop out of an all-ones write
    host.xfer(1'b1, IDX_SETUP, 32'h0000_00FF, v);
    rd_chk("setup reserved", IDX_SETUP, 32'h0000_0017);
    host.xfer(1'b1, 14'h0600, 32'hFFFF_FFFF, v);
    rd_chk("unmapped", 14'h0600, 32'h0000_0000);
    $display("test regs done");
  endtask

  task automatic t_expected();
    logic [63:0] e;
    e = 64'd40000 * 64'd7776 * 64'd237 / 64'd255;
    host.xfer(1'b1, IDX_BASE, 32'h0000_9C40, v);
    host.xfer(1'b1, IDX_MULT, 32'h0000_1E60, v);
    host.xfer(1'b1, IDX_NUM, 32'h0000_00ED, v);
    host.xfer(1'b1, IDX_DEN, 32'h0000_00FF, v);
    // Result settles 49 cycles after the last factor change
    repeat (60) @(posedge clk_i);
    chk("expected hz", e[47:0], exp_hz);
    $display("test expected done");
  endtask

  // Apply a setup byte to masked references and wait for completion
  task automatic apply(input logic [11:0] mask, input logic [7:0] s);
    host.xfer(1'b1, IDX_SETUP, {24'h000000, s}, v);
    host.page_xfer(mask, 1'b0, polls, v);
    chk("write done", 48'd0, {40'h0, v[7:0]});
    repeat (2) @(posedge clk_i);
  endtask

  task automatic t_modes();
    apply(12'h003, 8'h07);
    chk("diff pair", 48'h1, {46'h0, diff[1:0]});
    chk("lvpecl pair", 48'h0, {46'h0, lvpecl[1:0]});
    chk("acq on", 48'h3, {46'h0, acq_en[1:0]});
    apply(12'h00C, 8'h02);
    chk("single ended", 48'h0, {46'h0, diff[3:2]});
    chk("lvpecl single", 48'h3, {46'h0, lvpecl[3:2]});
    chk("acq off", 48'h0, {46'h0, acq_en[3:2]});
    chk("acq down", 48'h3, {46'h0, acq_pd[3:2]});
    apply(12'h008, 8'h06);
    chk("odd diff", 48'h0, {47'h0, diff[3]});
    chk("odd lvpecl", 48'h1, {47'h0, lvpecl[3]});
    chk("untouched", 48'h3F3, {38'h0, acq_en});
    $display("test modes done");
  endtask

  task automatic t_load();
    // Spoil the page so only a real load restores reference two
    host.xfer(1'b1, IDX_BASE, 32'h0000_1234, v);
    host.xfer(1'b1, IDX_SETUP, 32'h0000_0010, v);
    host.page_xfer(12'h004, 1'b1, polls, v);
    chk("read done", 48'd0, {40'h0, v[7:0]});
    rd_chk("load base", IDX_BASE, 32'h0000_9C40);
    rd_chk("load setup", IDX_SETUP, 32'h0000_0002);
    $display("test load done");
  endtask

  task automatic t_prediv();
    int n4, n5;
    logic p4, p5;
    n4 = 0;
    n5 = 0;
    p4 = 1'b0;
    p5 = 1'b0;
    host.xfer(1'b1, IDX_BASE, 32'h0000_4E20, v);
    // Reference zero halves too, so the divider assertion sees real edges
    apply(12'h011, 8'h11);
    apply(12'h020, 8'h01);
    // Pins toggle every 8 cycles; count over 16 whole periods once settled
    for (int i = 0; i < 320; i++)
    begin
      @(posedge clk_i);
      pins_i <= (i % 16 < 8) ? 10'h3FF : 10'h000;
      if (i >= 64)
      begin
        n4 += (ref_clk[4] === 1'b1 && p4 === 1'b0) ? 1 : 0;
        n5 += (ref_clk[5] === 1'b1 && p5 === 1'b0) ? 1 : 0;
      end
      p4 = ref_clk[4];
      p5 = ref_clk[5];
    end
    chk("halved edges", 48'd8, 48'(n4));
    chk("direct edges", 48'd16, 48'(n5));
    $display("test prediv done");
  endtask

  // ************************************************
  // Main sequence
  // ************************************************
  initial
  begin
    rst_i = 1'b1;
    pins_i = 10'h000;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_regs();
    t_expected();
    t_modes();
    t_load();
    t_prediv();
    report_and_stop();
  end
endmodule
